// ==== srgc_defines.vh ====
// Contract
// - Regulator drives torque or frequency correction.
// - Bypass input disables regulator, plain V/f.
// - Integral-disable input selects PI or P.
// - Integral-disable on: P only, integrator cleared.
// - Gain-select input on uses gain 2.
// - Gain-select input overrides speed-based switching.
// - Gain change ramps linearly over integral time 1.
// - Vector mode: set 2 low, set 1 high.
// - Zero switch frequency: set 1 everywhere.
// - V/f encoder: set 2 min, set 1 max.
// - Integrate during ramps only if enable is 1.
// - Clamp correction to the configured limit.
// - P scales error, I rate inverse time.
// - Hunting suppression only in V/f modes.
// - Hunting selection zero disables suppression.
// - Monitor one code 20: ramped reference.
// - Monitor two code 5: measured speed.
// - Level 1 gives bipolar full-scale range.
`ifndef SRGC_DEFINES_VH
`define SRGC_DEFINES_VH
`define SRGC_CLK_PERIOD_NS 10
`define SRGC_TICK_NS 1000000
`define SRGC_TICK_CYCLES (`SRGC_TICK_NS / `SRGC_CLK_PERIOD_NS)
`define SRGC_OFS_CTRL 8'h00
`define SRGC_OFS_ASSIGN_A 8'h04
`define SRGC_OFS_ASSIGN_B 8'h08
`define SRGC_OFS_PGAIN1 8'h0C
`define SRGC_OFS_ITIME1 8'h10
`define SRGC_OFS_PGAIN2 8'h14
`define SRGC_OFS_ITIME2 8'h18
`define SRGC_OFS_LIMIT 8'h1C
`define SRGC_OFS_SWFREQ 8'h20
`define SRGC_OFS_MINFREQ 8'h24
`define SRGC_OFS_MAXFREQ 8'h28
`define SRGC_OFS_HGAIN 8'h2C
`define SRGC_OFS_MONSEL 8'h30
`define SRGC_OFS_STATUS 8'h34
`define SRGC_OFS_INTEG 8'h38
`define SRGC_CTRL_MODE_LSB 0
`define SRGC_CTRL_RAMPI_BIT 2
`define SRGC_CTRL_HUNT_BIT 3
`define SRGC_MODE_VF 2'h0
`define SRGC_MODE_VFPG 2'h1
`define SRGC_MODE_OLV 2'h2
`define SRGC_MODE_CLV 2'h3
`define SRGC_FN_BYPASS 8'h0D
`define SRGC_FN_IDIS 8'h0E
`define SRGC_FN_GSEL 8'h77
`define SRGC_MON_REF 8'h14
`define SRGC_MON_SPEED 8'h05
`define SRGC_RST_CTRL 32'h0000_000B
`define SRGC_RST_ASSIGN 32'h0000_0000
`define SRGC_RST_PGAIN 16'h1400
`define SRGC_RST_ITIME 16'h01F4
`define SRGC_RST_LIMIT 16'h0666
`define SRGC_RST_SWFREQ 16'h0000
`define SRGC_RST_MINFREQ 16'h0100
`define SRGC_RST_MAXFREQ 16'h7FFF
`define SRGC_RST_HGAIN 16'h0100
`define SRGC_RST_MONSEL 18'h3_0514
`define SRGC_GAIN_FRAC 8
`endif

// ==== srgc_sync.v ====
`timescale 1ns/1ns
module srgc_sync #(
  parameter W = 5
) (
  input wire sys_clk_i, // clock
  input wire resetn_i, // sync reset, active low
  input wire [W-1:0] async_i, // pin levels
  output wire [W-1:0] sync_o // synchronised levels
);
  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;
  always @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      meta_ff <= {W{1'b0}};
      sync_ff <= {W{1'b0}};
    end
    else
    begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end
  assign sync_o = sync_ff;
endmodule

// ==== srgc_interp.v ====
`timescale 1ns/1ns
module srgc_interp (
  input wire [15:0] x_i, // position
  input wire [15:0] x0_i, // lower breakpoint
  input wire [15:0] x1_i, // upper breakpoint
  input wire [15:0] y0_i, // value at x0
  input wire [15:0] y1_i, // value at x1
  output reg [15:0] y_o // interpolated value
);
  wire signed [17:0] dy;
  wire [16:0] dx;
  wire [16:0] span;
  wire [16:0] span_nz;
  wire signed [35:0] prod;
  wire signed [35:0] quo;
  wire signed [35:0] res;
  assign dy = {2'h0, y1_i} - {2'h0, y0_i};
  assign dx = {1'h0, x_i} - {1'h0, x0_i};
  assign span = {1'h0, x1_i} - {1'h0, x0_i};
  // A zero span is never divided by; the clamps below take over.
  assign span_nz = (span == 17'h0_0000) ? 17'h0_0001 : span;
  assign prod = dy * $signed({1'h0, dx});
  assign quo = prod / $signed({19'h0_0000, span_nz});
  assign res = $signed({20'h0_0000, y0_i}) + quo;
  always @*
  begin
    if (x_i <= x0_i)
      y_o = y0_i;
    else if (x_i >= x1_i)
      y_o = y1_i;
    else
      y_o = res[15:0];
  end
endmodule

// ==== srgc_top.v ====
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ns
`include "srgc_defines.vh"
module srgc_top #(
  parameter TICK_CYCLES = `SRGC_TICK_CYCLES
) (
  input wire sys_clk_i, // 100 MHz clock
  input wire resetn_i, // sync reset, active low
  input wire [31:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // write address valid
  output wire s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // byte enables
  input wire s_axi_wvalid, // write data valid
  output wire s_axi_wready, // write data ready
  output reg [1:0] s_axi_bresp, // write response
  output reg s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire [31:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // read address valid
  output wire s_axi_arready, // read address ready
  output reg [31:0] s_axi_rdata, // read data
  output reg [1:0] s_axi_rresp, // read response
  output reg s_axi_rvalid, // read data valid
  input wire s_axi_rready, // read data ready
  input wire [4:0] multi_in_i, // digital input pins
  input wire signed [15:0] speed_ref_i, // reference after soft starter
  input wire signed [15:0] speed_fb_i, // encoder speed
  input wire ramp_active_i, // accel or decel in progress
  output reg signed [15:0] torque_ref_o, // torque reference
  output reg signed [15:0] freq_out_o, // output frequency
  output reg hunt_active_o, // hunting suppression on
  output reg [15:0] hunt_gain_o, // applied hunting gain
  output reg signed [15:0] monitor_out_one_o, // monitor 1, full scale 10 V
  output reg signed [15:0] monitor_out_two_o // monitor 2, full scale 10 V
);
  reg [31:0] ctrl_ff;
  reg [31:0] assign_a_ff;
  reg [31:0] assign_b_ff;
  reg [15:0] pg1_ff, it1_ff, pg2_ff, it2_ff;
  reg [15:0] limit_ff, swf_ff, minf_ff, maxf_ff, hgain_ff;
  reg [17:0] monsel_ff;
  reg aw_ok_ff, w_ok_ff;
  reg [7:0] awaddr_ff;
  reg [31:0] wdata_ff;
  reg [3:0] wstrb_ff;
  reg [16:0] tick_cnt_ff;
  reg tick_ff;
  reg [15:0] gain_app_ff;
  reg [15:0] itime_app_ff;
  reg [15:0] ramp_from_ff, ramp_to_ff, ramp_t_ff;
  reg ramping_ff;
  reg gsel_ff;
  reg signed [31:0] acc_ff;
  reg signed [15:0] corr_ff;
  wire [4:0] pins;
  wire [1:0] mode;
  wire bypass_in, idis_in, gsel_in, gsel_used;
  wire [15:0] abs_fb, abs_ref;
  wire [15:0] gi_x, gi_x0, gi_x1;
  wire [15:0] gain_sched, itime_sched, gain_ramp;
  reg [15:0] nxt_gain_app;
  wire [15:0] itime_div;
  wire signed [16:0] err;
  wire signed [33:0] p_raw;
  wire signed [31:0] p_term;
  wire signed [31:0] i_term;
  wire signed [31:0] acc_lim;
  wire signed [31:0] lim_s;
  reg signed [31:0] nxt_acc, sum;
  wire reg_active, integ_clear, integ_hold;
  wire wr_go, rd_hit;
  wire [31:0] wr_keep, wr_new;
  reg [31:0] rd_val;

  // Function sets the value carried by any input pin assigned to code fn.
  function fn_hit;
    input [4:0] lvl;
    input [39:0] codes;
    input [7:0] fn;
    integer k;
    begin
      fn_hit = 1'b0;
      for (k = 0; k < 5; k = k + 1)
        if (codes[8*k +: 8] == fn && lvl[k])
          fn_hit = 1'b1;
    end
  endfunction

  function [15:0] abs16;
    input signed [15:0] v;
    begin
      abs16 = v[15] ? (16'h0000 - v) : v;
    end
  endfunction

  function [15:0] mon_pick;
    input [7:0] sel;
    input lvl;
    input signed [15:0] ref_v;
    input signed [15:0] spd_v;
    reg signed [15:0] v;
    begin
      v = 16'h0000;
      if (sel == `SRGC_MON_REF)
        v = ref_v;
      else if (sel == `SRGC_MON_SPEED)
        v = spd_v;
      // Level 1 keeps the sign; any other level is unipolar.
      mon_pick = (lvl || !v[15]) ? v : 16'h0000;
    end
  endfunction

  srgc_sync #(.W(5)) u_sync (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .async_i(multi_in_i),
    .sync_o(pins));

  assign mode = ctrl_ff[`SRGC_CTRL_MODE_LSB +: 2];
  assign bypass_in = fn_hit(pins, {assign_b_ff[7:0], assign_a_ff}, `SRGC_FN_BYPASS);
  assign idis_in = fn_hit(pins, {assign_b_ff[7:0], assign_a_ff}, `SRGC_FN_IDIS);
  assign gsel_in = fn_hit(pins, {assign_b_ff[7:0], assign_a_ff}, `SRGC_FN_GSEL);
  assign gsel_used = fn_hit(5'h1F, {assign_b_ff[7:0], assign_a_ff}, `SRGC_FN_GSEL);
  assign abs_fb = abs16(speed_fb_i);
  assign abs_ref = abs16(speed_ref_i);

  // Vector mode schedules on speed, zero to switch frequency.
  // V/f encoder mode schedules on the speed reference, min to max.
  assign gi_x = (mode == `SRGC_MODE_VFPG) ? abs_ref : abs_fb;
  assign gi_x0 = (mode == `SRGC_MODE_VFPG) ? minf_ff : 16'h0000;
  assign gi_x1 = (mode == `SRGC_MODE_VFPG) ? maxf_ff : swf_ff;

  srgc_interp u_gain (.x_i(gi_x), .x0_i(gi_x0), .x1_i(gi_x1), .y0_i(pg2_ff), .y1_i(pg1_ff),
    .y_o(gain_sched));
  srgc_interp u_itime (.x_i(gi_x), .x0_i(gi_x0), .x1_i(gi_x1), .y0_i(it2_ff), .y1_i(it1_ff),
    .y_o(itime_sched));
  srgc_interp u_ramp (.x_i(ramp_t_ff), .x0_i(16'h0000), .x1_i(it1_ff), .y0_i(ramp_from_ff),
    .y1_i(ramp_to_ff), .y_o(gain_ramp));

  always @*
  begin
    // Hold for the edge on which the ramp registers load, so no step appears.
    if (gsel_used && gsel_in != gsel_ff)
      nxt_gain_app = gain_app_ff;
    else if (gsel_used && ramping_ff)
      nxt_gain_app = gain_ramp;
    else if (gsel_used)
      nxt_gain_app = gsel_in ? pg2_ff : pg1_ff;
    else if (mode == `SRGC_MODE_CLV && swf_ff == 16'h0000)
      nxt_gain_app = pg1_ff;
    else
      nxt_gain_app = gain_sched;
  end

  assign reg_active = (mode == `SRGC_MODE_CLV) ||
                      (mode == `SRGC_MODE_VFPG && !bypass_in);
  assign integ_clear = !reg_active || idis_in;
  assign integ_hold = ramp_active_i && !ctrl_ff[`SRGC_CTRL_RAMPI_BIT];

  assign itime_div = (itime_app_ff == 16'h0000) ? 16'h0001 : itime_app_ff;
  assign err = {speed_ref_i[15], speed_ref_i} - {speed_fb_i[15], speed_fb_i};
  assign p_raw = $signed({1'b0, gain_app_ff}) * err;
  assign p_term = $signed(p_raw[33:2]) >>> (`SRGC_GAIN_FRAC - 2);
  // Integral part is the sum of scaled errors per tick over the time.
  assign i_term = acc_ff / $signed({16'h0000, itime_div});
  assign lim_s = $signed({16'h0000, limit_ff});
  // Clamping the sum to limit times time keeps the I part within limit.
  assign acc_lim = $signed({16'h0000, limit_ff}) * $signed({16'h0000, itime_div});

  always @*
  begin
    nxt_acc = acc_ff;
    if (integ_clear)
      nxt_acc = 32'h0000_0000;
    else if (tick_ff && !integ_hold)
      nxt_acc = acc_ff + p_term;
    if (nxt_acc > acc_lim)
      nxt_acc = acc_lim;
    else if (nxt_acc < -acc_lim)
      nxt_acc = -acc_lim;
  end

  always @*
  begin
    sum = idis_in ? p_term : (p_term + i_term);
    if (!reg_active)
      sum = 32'h0000_0000;
    else if (sum > lim_s)
      sum = lim_s;
    else if (sum < -lim_s)
      sum = -lim_s;
  end

  always @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      tick_cnt_ff <= 17'h0_0000;
      tick_ff <= 1'b0;
      gain_app_ff <= `SRGC_RST_PGAIN;
      itime_app_ff <= `SRGC_RST_ITIME;
      ramp_from_ff <= `SRGC_RST_PGAIN;
      ramp_to_ff <= `SRGC_RST_PGAIN;
      ramp_t_ff <= 16'h0000;
      ramping_ff <= 1'b0;
      gsel_ff <= 1'b0;
      acc_ff <= 32'h0000_0000;
      corr_ff <= 16'h0000;
      torque_ref_o <= 16'h0000;
      freq_out_o <= 16'h0000;
      hunt_active_o <= 1'b0;
      hunt_gain_o <= 16'h0000;
      monitor_out_one_o <= 16'h0000;
      monitor_out_two_o <= 16'h0000;
    end
    else
    begin
      tick_ff <= (tick_cnt_ff == TICK_CYCLES[16:0] - 17'h0_0001);
      if (tick_cnt_ff == TICK_CYCLES[16:0] - 17'h0_0001)
        tick_cnt_ff <= 17'h0_0000;
      else
        tick_cnt_ff <= tick_cnt_ff + 17'h0_0001;
      gsel_ff <= gsel_in;
      gain_app_ff <= nxt_gain_app;
      if (gsel_used && gsel_in != gsel_ff)
      begin
        ramp_from_ff <= gain_app_ff;
        ramp_to_ff <= gsel_in ? pg2_ff : pg1_ff;
        ramp_t_ff <= 16'h0000;
        ramping_ff <= 1'b1;
      end
      else if (ramping_ff && tick_ff)
      begin
        ramp_t_ff <= ramp_t_ff + 16'h0001;
        if (ramp_t_ff + 16'h0001 >= it1_ff)
          ramping_ff <= 1'b0;
      end
      if (mode == `SRGC_MODE_CLV && swf_ff == 16'h0000)
        itime_app_ff <= it1_ff;
      else
        itime_app_ff <= itime_sched;
      acc_ff <= nxt_acc;
      corr_ff <= sum[15:0];
      torque_ref_o <= (mode == `SRGC_MODE_CLV) ? corr_ff : 16'h0000;
      freq_out_o <= (mode == `SRGC_MODE_VFPG) ? speed_ref_i + corr_ff : speed_ref_i;
      hunt_active_o <= (mode == `SRGC_MODE_VF || mode == `SRGC_MODE_VFPG) &&
                       ctrl_ff[`SRGC_CTRL_HUNT_BIT];
      hunt_gain_o <= ((mode == `SRGC_MODE_VF || mode == `SRGC_MODE_VFPG) &&
                      ctrl_ff[`SRGC_CTRL_HUNT_BIT]) ? hgain_ff : 16'h0000;
      monitor_out_one_o <= mon_pick(monsel_ff[7:0], monsel_ff[16], speed_ref_i, speed_fb_i);
      monitor_out_two_o <= mon_pick(monsel_ff[15:8], monsel_ff[17], speed_ref_i, speed_fb_i);
    end
  end

  // Address and data are latched independently; one write at a time.
  assign s_axi_awready = !aw_ok_ff && !s_axi_bvalid;
  assign s_axi_wready = !w_ok_ff && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go = aw_ok_ff && w_ok_ff;
  // Byte lanes that are not strobed keep their old bits.
  assign wr_keep = ~{{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
  assign wr_new = wdata_ff & ~wr_keep;

  always @*
  begin
    rd_val = 32'h0000_0000;
    case (s_axi_araddr[7:0])
      `SRGC_OFS_CTRL: rd_val = {28'h000_0000, ctrl_ff[3:0]};
      `SRGC_OFS_ASSIGN_A: rd_val = assign_a_ff;
      `SRGC_OFS_ASSIGN_B: rd_val = {24'h00_0000, assign_b_ff[7:0]};
      `SRGC_OFS_PGAIN1: rd_val = {16'h0000, pg1_ff};
      `SRGC_OFS_ITIME1: rd_val = {16'h0000, it1_ff};
      `SRGC_OFS_PGAIN2: rd_val = {16'h0000, pg2_ff};
      `SRGC_OFS_ITIME2: rd_val = {16'h0000, it2_ff};
      `SRGC_OFS_LIMIT: rd_val = {16'h0000, limit_ff};
      `SRGC_OFS_SWFREQ: rd_val = {16'h0000, swf_ff};
      `SRGC_OFS_MINFREQ: rd_val = {16'h0000, minf_ff};
      `SRGC_OFS_MAXFREQ: rd_val = {16'h0000, maxf_ff};
      `SRGC_OFS_HGAIN: rd_val = {16'h0000, hgain_ff};
      `SRGC_OFS_MONSEL: rd_val = {14'h0000, monsel_ff};
      `SRGC_OFS_STATUS: rd_val = {12'h000, ramping_ff, hunt_active_o, !reg_active,
                                  integ_clear, gain_app_ff};
      `SRGC_OFS_INTEG: rd_val = acc_ff;
      default: rd_val = 32'h0000_0000;
    endcase
  end
  assign rd_hit = (s_axi_araddr[7:0] <= `SRGC_OFS_INTEG) &&
                  (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr[31:8] == 24'h00_0000);

  always @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      aw_ok_ff <= 1'b0;
      w_ok_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h0000_0000;
      ctrl_ff <= `SRGC_RST_CTRL;
      assign_a_ff <= `SRGC_RST_ASSIGN;
      assign_b_ff <= `SRGC_RST_ASSIGN;
      pg1_ff <= `SRGC_RST_PGAIN;
      it1_ff <= `SRGC_RST_ITIME;
      pg2_ff <= `SRGC_RST_PGAIN;
      it2_ff <= `SRGC_RST_ITIME;
      limit_ff <= `SRGC_RST_LIMIT;
      swf_ff <= `SRGC_RST_SWFREQ;
      minf_ff <= `SRGC_RST_MINFREQ;
      maxf_ff <= `SRGC_RST_MAXFREQ;
      hgain_ff <= `SRGC_RST_HGAIN;
      monsel_ff <= `SRGC_RST_MONSEL;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_ok_ff <= 1'b1;
        awaddr_ff <= (s_axi_awaddr[31:8] == 24'h00_0000) ? s_axi_awaddr[7:0] : 8'hFF;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_ok_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_ok_ff <= 1'b0;
        w_ok_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        case (awaddr_ff)
          `SRGC_OFS_CTRL: ctrl_ff <= ((ctrl_ff & wr_keep) | wr_new) & 32'h0000_000F;
          `SRGC_OFS_ASSIGN_A: assign_a_ff <= (assign_a_ff & wr_keep) | wr_new;
          `SRGC_OFS_ASSIGN_B: assign_b_ff <= ((assign_b_ff & wr_keep) | wr_new) &
                                             32'h0000_00FF;
          `SRGC_OFS_PGAIN1: pg1_ff <= (pg1_ff & wr_keep[15:0]) | wr_new[15:0];
          `SRGC_OFS_ITIME1: it1_ff <= (it1_ff & wr_keep[15:0]) | wr_new[15:0];
          `SRGC_OFS_PGAIN2: pg2_ff <= (pg2_ff & wr_keep[15:0]) | wr_new[15:0];
          `SRGC_OFS_ITIME2: it2_ff <= (it2_ff & wr_keep[15:0]) | wr_new[15:0];
          `SRGC_OFS_LIMIT: limit_ff <= (limit_ff & wr_keep[15:0]) | wr_new[15:0];
          `SRGC_OFS_SWFREQ: swf_ff <= (swf_ff & wr_keep[15:0]) | wr_new[15:0];
          `SRGC_OFS_MINFREQ: minf_ff <= (minf_ff & wr_keep[15:0]) | wr_new[15:0];
          `SRGC_OFS_MAXFREQ: maxf_ff <= (maxf_ff & wr_keep[15:0]) | wr_new[15:0];
          `SRGC_OFS_HGAIN: hgain_ff <= (hgain_ff & wr_keep[15:0]) | wr_new[15:0];
          `SRGC_OFS_MONSEL: monsel_ff <= (monsel_ff & wr_keep[17:0]) | wr_new[17:0];
          `SRGC_OFS_STATUS: s_axi_bresp <= 2'h0;
          `SRGC_OFS_INTEG: s_axi_bresp <= 2'h0;
          default: s_axi_bresp <= 2'h2;
        endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_hit ? rd_val : 32'h0000_0000;
        s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// ==== srgc_top_assertions.sv ====
`timescale 1ns/1ns
module srgc_checker #(
  parameter TICK_CYCLES = 10
) (
  input wire sys_clk_i, // clock
  input wire resetn_i, // sync reset, active low
  input wire s_axi_awvalid, // write address valid
  input wire s_axi_awready, // write address ready
  input wire s_axi_wvalid, // write data valid
  input wire s_axi_wready, // write data ready
  input wire [1:0] s_axi_bresp, // write response
  input wire s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire s_axi_arvalid, // read address valid
  input wire s_axi_arready, // read address ready
  input wire [31:0] s_axi_rdata, // read data
  input wire [1:0] s_axi_rresp, // read response
  input wire s_axi_rvalid, // read data valid
  input wire s_axi_rready, // read data ready
  input wire hunt_active_o, // hunting suppression on
  input wire [15:0] hunt_gain_o // applied hunting gain
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_wr_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  chk_rd_answer: assert property (s_rd_taken |-> ##[1:2] s_axi_rvalid)
    else $error("read response missing");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_b_blocks: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  chk_resp_code: assert property ((s_axi_bvalid |-> !s_axi_bresp[0]) and (s_axi_rvalid |-> !s_axi_rresp[0]))
    else $error("illegal response code");
  chk_hunt_gain: assert property (!hunt_active_o |-> hunt_gain_o == 16'h0000)
    else $error("hunting gain applied while off");
endmodule
bind srgc_top srgc_checker #(.TICK_CYCLES(TICK_CYCLES)) srgc_checker_inst (.sys_clk_i(sys_clk_i),
  .resetn_i(resetn_i), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .hunt_active_o(hunt_active_o),
  .hunt_gain_o(hunt_gain_o));

// ==== srgc_motor_model.sv ====
`timescale 1ns/1ns
module srgc_motor_model (
  input wire logic sys_clk_i, // clock
  input wire logic signed [15:0] speed_set_i, // shaft speed imposed by the bench
  output logic signed [15:0] speed_fb_o // encoder speed
);
  // The encoder reports one clock late, as a sampled count would.
  initial speed_fb_o = 16'sh0000;
  always @(posedge sys_clk_i)
  begin
    speed_fb_o <= speed_set_i;
  end
endmodule

// ==== srgc_top_tb.sv ====
`timescale 1ns/1ns
`include "srgc_defines.vh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_fail++; $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module srgc_top_tb;
  logic sys_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, hact;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, d;
  logic [4:0] pins = 5'h00;
  logic ramp = 1'b0;
  logic signed [15:0] sref = 16'sh0000, sset = 16'sh0000, sfb, tq, fq, m1, m2;
  logic [15:0] hgain;
  int n_fail = 0;
  int compares = 0;
  logic [7:0] ra [10] = '{`SRGC_OFS_CTRL, `SRGC_OFS_PGAIN1, `SRGC_OFS_ITIME1, `SRGC_OFS_PGAIN2,
    `SRGC_OFS_LIMIT, `SRGC_OFS_MINFREQ, `SRGC_OFS_MAXFREQ, `SRGC_OFS_MONSEL, `SRGC_OFS_HGAIN,
    `SRGC_OFS_SWFREQ};
  logic [31:0] rv [10] = '{32'hB, 32'h1400, 32'h1F4, 32'h1400, 32'h666, 32'h100, 32'h7FFF,
    32'h30514, 32'h100, 32'h0};
  always #5 sys_clk_i = ~sys_clk_i;
  srgc_motor_model srgc_motor_model_inst (.sys_clk_i(sys_clk_i), .speed_set_i(sset), .speed_fb_o(sfb));
  srgc_top #(.TICK_CYCLES(10)) srgc_top_inst (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .multi_in_i(pins), .speed_ref_i(sref), .speed_fb_i(sfb),
    .ramp_active_i(ramp), .torque_ref_o(tq), .freq_out_o(fq), .hunt_active_o(hact),
    .hunt_gain_o(hgain), .monitor_out_one_o(m1), .monitor_out_two_o(m2));
  task wt(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task wr(input [7:0] a, input [31:0] v, input [1:0] er);
    logic ad, wd;
    begin
      ad = 1'b0;
      wd = 1'b0;
      awaddr <= {24'h0, a};
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(ad && wd))
      begin
        @(posedge sys_clk_i);
        if (awvalid && awready)
          ad = 1'b1;
        if (wvalid && wready)
          wd = 1'b1;
        awvalid <= !ad;
        wvalid <= !wd;
      end
      do
        @(posedge sys_clk_i);
      while (!bvalid);
      bready <= 1'b0;
      `CHK(bresp, er)
      // An idle edge keeps the next call from rewriting a ready in the same step.
      @(posedge sys_clk_i);
    end
  endtask
  task rd(input [7:0] a, input [1:0] er);
    begin
      araddr <= {24'h0, a};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
        @(posedge sys_clk_i);
      while (!(arvalid && arready));
      arvalid <= 1'b0;
      do
        @(posedge sys_clk_i);
      while (!rvalid);
      rready <= 1'b0;
      d = rdata;
      `CHK(rresp, er)
      @(posedge sys_clk_i);
    end
  endtask
  task gain(input [15:0] e);
    begin
      wt(5);
      rd(`SRGC_OFS_STATUS, 2'h0);
      `CHK(d[15:0], e)
    end
  endtask
  task complete_run;
    begin
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  initial
  begin
    wt(12);
    resetn_i <= 1'b1;
    wt(1);
    for (int i = 0; i < 10; i++)
    begin
      rd(ra[i], 2'h0);
      `CHK(d, rv[i])
    end
    rd(8'h3C, 2'h2);
    `CHK(d, 32'h0)
    wr(8'h40, 32'h1, 2'h2);
    `CHK(hact, 1'b0)
    $display("test reset_map done");
    wr(`SRGC_OFS_PGAIN1, 32'h0800, 2'h0);
    wr(`SRGC_OFS_PGAIN2, 32'h1000, 2'h0);
    wr(`SRGC_OFS_ITIME1, 32'h4, 2'h0);
    sset <= 16'sh2000;
    gain(16'h0800);
    wr(`SRGC_OFS_SWFREQ, 32'h1000, 2'h0);
    sset <= 16'sh0000;
    gain(16'h1000);
    sset <= 16'sh0800;
    gain(16'h0C00);
    sset <= 16'sh1000;
    gain(16'h0800);
    // Input 0 selects gain 2 while the schedule above would keep gain 1.
    wr(`SRGC_OFS_ASSIGN_A, 32'h77, 2'h0);
    pins <= 5'h01;
    wt(15);
    rd(`SRGC_OFS_STATUS, 2'h0);
    `CHK(d[19], 1'b1)
    `CHK(d[15:0] > 16'h0800 && d[15:0] < 16'h1000, 1'b1)
    wt(60);
    gain(16'h1000);
    pins <= 5'h00;
    wt(60);
    gain(16'h0800);
    $display("test gain_select done");
    wr(`SRGC_OFS_ASSIGN_A, 32'h0E, 2'h0);
    sref <= 16'sh0100;
    sset <= 16'sh0000;
    wt(40);
    rd(`SRGC_OFS_INTEG, 2'h0);
    `CHK($signed(d) > 0, 1'b1)
    pins <= 5'h01;
    wt(10);
    rd(`SRGC_OFS_INTEG, 2'h0);
    `CHK(d, 32'h0)
    rd(`SRGC_OFS_STATUS, 2'h0);
    `CHK(d[16], 1'b1)
    pins <= 5'h00;
    ramp <= 1'b1;
    wt(40);
    rd(`SRGC_OFS_INTEG, 2'h0);
    `CHK(d, 32'h0)
    wr(`SRGC_OFS_CTRL, 32'h7, 2'h0);
    wt(40);
    rd(`SRGC_OFS_INTEG, 2'h0);
    `CHK(d != 32'h0, 1'b1)
    ramp <= 1'b0;
    $display("test integrator done");
    pins <= 5'h01;
    sref <= 16'sh4000;
    wt(8);
    `CHK(tq, 16'sh0666)
    sref <= -16'sh4000;
    sset <= 16'sh0123;
    wt(8);
    `CHK(tq, -16'sh0666)
    `CHK(m1, -16'sh4000)
    `CHK(m2, 16'sh0123)
    wr(`SRGC_OFS_MONSEL, 32'h0514, 2'h0);
    wt(4);
    `CHK(m1, 16'sh0000)
    $display("test clamp_monitor done");
    wr(`SRGC_OFS_CTRL, 32'h1, 2'h0);
    wr(`SRGC_OFS_ASSIGN_A, 32'h0D0E, 2'h0);
    wr(`SRGC_OFS_MAXFREQ, 32'h2100, 2'h0);
    sset <= 16'sh0000;
    sref <= 16'sh0100;
    gain(16'h1000);
    sref <= 16'sh2100;
    gain(16'h0800);
    sref <= 16'sh1100;
    gain(16'h0C00);
    sref <= 16'sh1000;
    wt(8);
    `CHK(fq, 16'sh1666)
    `CHK(tq, 16'sh0000)
    pins <= 5'h03;
    wt(8);
    `CHK(fq, 16'sh1000)
    rd(`SRGC_OFS_STATUS, 2'h0);
    `CHK(d[17], 1'b1)
    $display("test encoder_vf done");
    wr(`SRGC_OFS_CTRL, 32'h8, 2'h0);
    wt(4);
    `CHK(hact, 1'b1)
    `CHK(hgain, 16'h0100)
    wr(`SRGC_OFS_CTRL, 32'hA, 2'h0);
    wt(4);
    `CHK(hact, 1'b0)
    wr(`SRGC_OFS_CTRL, 32'h0, 2'h0);
    wt(4);
    `CHK(hact, 1'b0)
    `CHK(hgain, 16'h0000)
    $display("test hunting done");
    complete_run;
  end
  initial
  begin
    repeat (20000) @(posedge sys_clk_i);
    n_fail++;
    complete_run;
  end
endmodule
